/* File: rtl/ext_bus_params.svh */
// constants of the external bus pin control block
// assumes inclusion by the package and design files by bare name
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
`define EXT_ADDR_W 20
`define EXT_LOW_ADDR_W 16
`define EXT_DATA_W 16
`define EXT_MIN_SW_WAIT 2
`define EXT_WAIT_W 3
`define EXT_KEEPER_RESET 1'b0
`endif

/* File: rtl/ext_bus_pkg.sv */
// types of the external bus pin control block
// assumes the params header is on the include path
`include "ext_bus_params.svh"
package ext_bus_pkg;
    typedef enum logic [1:0] {
        SPACE_PROG,
        SPACE_DATA,
        SPACE_IO
    } space_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_READY
    } bus_state_t;
endpackage

/* File: rtl/data_keeper.sv */
// data pin bus keeper: remembers the last level on each data pin
// assumes pin levels already synchronised to clk
`timescale 1ns/1ps
module data_keeper #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_level,
    input wire logic drive_en,
    input wire logic [WIDTH-1:0] drive_val,
    output logic [WIDTH-1:0] held_q
);
    // **********************************
    // last level memory
    // **********************************
    always_ff @(posedge clk) begin
        if (rst) begin
            held_q <= '0;
        end else if (drive_en) begin
            held_q <= drive_val;
        end else begin
            held_q <= pin_level;
        end
    end
endmodule

/* File: rtl/ext_bus_ctrl.sv */
// external parallel bus pin control: address, data, strobes, acknowledge
// assumes core requests are on clk; pins go through a pad wrapper using the enables
`timescale 1ns/1ps
`include "ext_bus_params.svh"
// Functional notes
// - low sixteen address lines address program, data and I/O spaces
// - address bits 16..19 used only for program space accesses
// - all address outputs float in hold or while float input low
// - sixteen-bit shared bidirectional data bus, bit 15 most significant
// - data drivers off unless writing, and during reset or hold
// - data drivers off whenever float input is low
// - enabled keepers hold undriven data pins at last level
// - keepers disabled out of reset
// - one software control bit enables or disables keepers
// - acknowledge output marks vector fetch on low sixteen address lines
// - acknowledge output floats while float input low
// - with two or more wait states, sample ready after them; low extends
// - memory strobe high, low only during program or data memory access
// - direction output high, low only during external write
module ext_bus_ctrl #(
    parameter int ADDR_W = `EXT_ADDR_W,
    parameter int DATA_W = `EXT_DATA_W,
    parameter int WAIT_W = `EXT_WAIT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_in_n,
    input wire logic hold_req_n,
    input wire logic float_n,
    input wire logic ready,
    input wire logic req_valid,
    output logic req_ready,
    input wire ext_bus_pkg::space_t req_space,
    input wire logic req_write,
    input wire logic req_vector,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [WAIT_W-1:0] sw_wait,
    input wire logic keeper_wr,
    input wire logic keeper_wdata,
    output logic bus_keeper_en,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic hold_ack,
    output logic [ADDR_W-1:0] addr_o,
    output logic addr_oe,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe,
    output logic [DATA_W-1:0] data_keep_o,
    output logic data_keep_oe,
    output logic mem_strobe_n,
    output logic io_strobe_n,
    output logic rw_o,
    output logic ctrl_oe,
    output logic int_ack_out,
    output logic int_ack_oe
);
    import ext_bus_pkg::*;

    // refuse widths the address split and ready threshold cannot serve
    if (ADDR_W != `EXT_ADDR_W || DATA_W != `EXT_DATA_W || WAIT_W < 2) begin : g_bad_params
        $error("ext_bus_ctrl: unsupported parameter values");
    end

    // **********************************
    // pin synchronisers
    // **********************************
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [DATA_W-1:0] dsync1_q;
    logic [DATA_W-1:0] dsync2_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            dsync1_q <= '0;
            dsync2_q <= '0;
        end else begin
            sync1_q <= {reset_in_n, hold_req_n, float_n, ready};
            sync2_q <= sync1_q;
            dsync1_q <= data_i;
            dsync2_q <= dsync1_q;
        end
    end
    wire reset_pin_n_s = sync2_q[3];
    wire hold_n_s = sync2_q[2];
    wire float_n_s = sync2_q[1];
    wire ready_s = sync2_q[0];

    // **********************************
    // common output enable
    // **********************************
    logic hold_q;
    wire in_reset = rst | ~reset_pin_n_s;
    wire bus_oe = ~in_reset & ~hold_q & float_n_s;

    // **********************************
    // keeper control bit
    // **********************************
    logic keeper_q;
    always_ff @(posedge clk) begin
        if (in_reset) begin
            keeper_q <= `EXT_KEEPER_RESET;
        end else if (keeper_wr) begin
            keeper_q <= keeper_wdata;
        end
    end
    assign bus_keeper_en = keeper_q;

    // **********************************
    // access sequencer
    // **********************************
    bus_state_t state_q;
    bus_state_t state_d;
    logic [WAIT_W-1:0] wait_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic write_q;
    logic vector_q;
    space_t space_q;
    logic check_ready_q;
    logic [DATA_W-1:0] rdata_q;
    logic rsp_q;

    wire idle = state_q == ST_IDLE;
    wire can_start = idle & ~in_reset & ~hold_q & hold_n_s;
    wire take = req_valid & can_start;
    assign req_ready = can_start;
    wire wait_done = wait_q == '0;
    wire ready_ok = ~check_ready_q | ready_s;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = (sw_wait == '0) ? ST_READY : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_done) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                if (ready_ok) begin
                    state_d = ST_IDLE; // with two or more wait states, low ready holds ST_READY until ready is sampled high
                end
            end
        endcase
    end

    // program space keeps 20 bits except vector fetches; other spaces and vector fetches use the low 16 only
    wire [ADDR_W-1:0] addr_sel = (req_space == SPACE_PROG && !req_vector) ? req_addr :
        {{(ADDR_W-`EXT_LOW_ADDR_W){1'b0}}, req_addr[`EXT_LOW_ADDR_W-1:0]};

    always_ff @(posedge clk) begin
        if (in_reset) begin
            state_q <= ST_IDLE;
            wait_q <= '0;
            addr_q <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
            vector_q <= 1'b0;
            space_q <= SPACE_PROG;
            check_ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (take) begin
                wait_q <= (sw_wait == '0) ? '0 : sw_wait - 1'b1;
                check_ready_q <= sw_wait >= WAIT_W'(`EXT_MIN_SW_WAIT);
                addr_q <= addr_sel;
                wdata_q <= req_wdata;
                write_q <= req_write & ~req_vector;
                vector_q <= req_vector;
                space_q <= req_vector ? SPACE_PROG : req_space;
            end else if (state_q == ST_WAIT && !wait_done) begin
                wait_q <= wait_q - 1'b1;
            end
        end
    end

    // **********************************
    // hold handshake
    // **********************************
    always_ff @(posedge clk) begin
        if (in_reset) begin
            hold_q <= 1'b0;
        end else if (!hold_n_s && idle) begin
            hold_q <= 1'b1;
        end else if (hold_n_s) begin
            hold_q <= 1'b0;
        end
    end
    assign hold_ack = hold_q;

    // **********************************
    // read data return
    // **********************************
    wire finish = state_q == ST_READY && ready_ok;
    always_ff @(posedge clk) begin
        if (in_reset) begin
            rdata_q <= '0;
            rsp_q <= 1'b0;
        end else begin
            rsp_q <= finish;
            if (finish && !write_q) begin
                rdata_q <= dsync2_q;
            end
        end
    end
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;

    // **********************************
    // pin drivers
    // **********************************
    wire active = ~idle;
    wire mem_acc = active & (space_q != SPACE_IO);
    assign addr_o = addr_q;
    assign addr_oe = bus_oe;
    assign data_o = wdata_q;
    assign data_oe = bus_oe & active & write_q;
    assign mem_strobe_n = ~mem_acc;
    assign io_strobe_n = ~(active & (space_q == SPACE_IO));
    assign rw_o = ~(active & write_q);
    assign ctrl_oe = bus_oe;
    assign int_ack_out = ~(active & vector_q);
    assign int_ack_oe = ~in_reset & float_n_s;

    // **********************************
    // bus keeper
    // **********************************
    // while the keeper drives, it must not resample its own delayed pin image
    wire keep_load = data_oe | data_keep_oe;
    wire [DATA_W-1:0] keep_val = data_oe ? wdata_q : (finish && !write_q) ? dsync2_q : data_keep_o;
    data_keeper #(
        .WIDTH(DATA_W)
    ) u_keeper (
        .clk(clk),
        .rst(rst),
        .pin_level(dsync2_q),
        .drive_en(keep_load),
        .drive_val(keep_val),
        .held_q(data_keep_o)
    );
    assign data_keep_oe = keeper_q & ~data_oe;
endmodule

/* File: tb/ext_bus_monitor.sv */
// checker of the bus pin outputs
// assumes bind to ext_bus_ctrl at default widths
`timescale 1ns/1ps
// ****
// checker
// ****
module ext_bus_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic float_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic keeper_wr,
    input wire logic keeper_wdata,
    input wire logic bus_keeper_en,
    input wire logic rsp_valid,
    input wire logic [19:0] addr_o,
    input wire logic addr_oe,
    input wire logic data_oe,
    input wire logic mem_strobe_n,
    input wire logic io_strobe_n,
    input wire logic rw_o,
    input wire logic ctrl_oe,
    input wire logic int_ack_out,
    input wire logic int_ack_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    float_off_a: assert property (!float_n [*3] |-> !(addr_oe || data_oe || int_ack_oe))
        else $error("float");
    data_write_a: assert property (data_oe |-> !rw_o) else $error("data drive");
    keeper_reset_a: assert property (disable iff (1'h0) rst |=> !bus_keeper_en) else $error("keeper reset");
    keeper_write_a: assert property (keeper_wr |=> bus_keeper_en == $past(keeper_wdata)) else $error("keeper");
    io_upper_a: assert property (!io_strobe_n |-> addr_o[19:16] == 4'h0) else $error("io addr");
    strobe_excl_a: assert property (!mem_strobe_n |-> io_strobe_n) else $error("strobes");
    rsp_bound_a: assert property (req_valid && req_ready |-> ##[2:40] rsp_valid) else $error("no answer");
    common_oe_a: assert property (!addr_oe |-> !(ctrl_oe || data_oe)) else $error("enables");
    ack_vector_a: assert property (!int_ack_out |-> addr_o[19:16] == 4'h0) else $error("ack addr");
    rw_access_a: assert property (!rw_o |-> !(mem_strobe_n && io_strobe_n)) else $error("rw");
    cover property (req_valid && req_ready);
    cover property ($rose(bus_keeper_en));
    cover property (!float_n [*3]);
    cover property (!int_ack_out);
endmodule
bind ext_bus_ctrl ext_bus_monitor mon (
    .clk(clk), .rst(rst), .float_n(float_n), .req_valid(req_valid), .req_ready(req_ready), .keeper_wr(keeper_wr),
    .keeper_wdata(keeper_wdata), .bus_keeper_en(bus_keeper_en), .rsp_valid(rsp_valid), .addr_o(addr_o),
    .addr_oe(addr_oe), .data_oe(data_oe), .mem_strobe_n(mem_strobe_n), .io_strobe_n(io_strobe_n), .rw_o(rw_o),
    .ctrl_oe(ctrl_oe), .int_ack_out(int_ack_out), .int_ack_oe(int_ack_oe)
);

/* File: tb/ext_mem_model.sv */
// pin-level model of external memory and I/O devices
// assumes one 16-word store shared by all spaces
`timescale 1ns/1ps
// ****
// model
// ****
module ext_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic [19:0] addr_o,
    input wire logic [15:0] data_o,
    input wire logic data_oe,
    input wire logic [15:0] data_keep_o,
    input wire logic data_keep_oe,
    input wire logic mem_strobe_n,
    input wire logic io_strobe_n,
    input wire logic rw_o,
    output logic ready,
    output logic [15:0] data_i
);
    logic [15:0] mem_q [16] = '{default: 16'h0};
    logic [15:0] last_q = 16'h0;
    logic [2:0] stall_q = 3'h0;
    wire logic sel = !(mem_strobe_n && io_strobe_n);
    // wire level: controller driver, addressed memory or I/O, weak keeper, else a changing pattern
    assign data_i = data_oe ? data_o : sel && rw_o ? mem_q[addr_o[3:0]] : data_keep_oe ? data_keep_o : ~last_q;
    assign ready = !slow || stall_q == 3'h4;
    always @(posedge clk) begin
        last_q <= data_i;
        stall_q <= sel ? stall_q + 3'(stall_q != 3'h4) : 3'h0;
        if (sel && !rw_o) mem_q[addr_o[3:0]] <= data_o;
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the bus pin control block
// assumes the pin model answers on data_i and ready
`timescale 1ns/1ps
// ****
// bench
// ****
module testbench;
    import ext_bus_pkg::*;
    typedef struct {space_t sp; logic wr; logic [19:0] a; logic [15:0] d; logic [19:0] ea;} row_t;
    logic clk = 1'h0, rst = 1'h1, reset_in_n = 1'h1, hold_req_n = 1'h1, float_n = 1'h1, slow = 1'h0;
    logic req_valid = 1'h0, req_write = 1'h0, req_vector = 1'h0, keeper_wr = 1'h0, keeper_wdata = 1'h0;
    logic ready, req_ready, bus_keeper_en, rsp_valid, hold_ack, addr_oe, data_oe, data_keep_oe, ack, rwl;
    logic mem_strobe_n, io_strobe_n, rw_o, ctrl_oe, int_ack_out, int_ack_oe;
    logic [2:0] sw_wait = 3'h0;
    logic [19:0] req_addr = 20'h0, addr_o, seen;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, data_i, data_o, data_keep_o, kept;
    space_t req_space = SPACE_PROG;
    int fails = 0, total_checks = 0, lat;
    row_t rows [6] = '{'{SPACE_PROG, 1'h1, 20'h5a001, 16'h1234, 20'h5a001},
        '{SPACE_DATA, 1'h1, 20'h3c002, 16'hc3a5, 20'h0c002}, '{SPACE_IO, 1'h1, 20'hf0003, 16'h8001, 20'h00003},
        '{SPACE_PROG, 1'h0, 20'h5a001, 16'h1234, 20'h5a001}, '{SPACE_DATA, 1'h0, 20'h3c002, 16'hc3a5, 20'h0c002},
        '{SPACE_IO, 1'h0, 20'hf0003, 16'h8001, 20'h00003}};
    ext_bus_ctrl DUT (
        .clk(clk), .rst(rst), .reset_in_n(reset_in_n), .hold_req_n(hold_req_n), .float_n(float_n), .ready(ready),
        .req_valid(req_valid), .req_ready(req_ready), .req_space(req_space), .req_write(req_write),
        .req_vector(req_vector), .req_addr(req_addr), .req_wdata(req_wdata), .sw_wait(sw_wait),
        .keeper_wr(keeper_wr), .keeper_wdata(keeper_wdata), .bus_keeper_en(bus_keeper_en), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .hold_ack(hold_ack), .addr_o(addr_o), .addr_oe(addr_oe), .data_i(data_i),
        .data_o(data_o), .data_oe(data_oe), .data_keep_o(data_keep_o), .data_keep_oe(data_keep_oe),
        .mem_strobe_n(mem_strobe_n), .io_strobe_n(io_strobe_n), .rw_o(rw_o), .ctrl_oe(ctrl_oe),
        .int_ack_out(int_ack_out), .int_ack_oe(int_ack_oe)
    );
    ext_mem_model model (
        .clk(clk), .slow(slow), .addr_o(addr_o), .data_o(data_o), .data_oe(data_oe), .data_keep_o(data_keep_o),
        .data_keep_oe(data_keep_oe), .mem_strobe_n(mem_strobe_n), .io_strobe_n(io_strobe_n), .rw_o(rw_o),
        .ready(ready), .data_i(data_i)
    );
    initial forever #2.5 clk = ~clk;
    task check(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'h1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic access(input space_t sp, input logic wr, vec, input logic [19:0] a, input logic [15:0] d,
        input logic [2:0] w);
        int n = 0;
        @(posedge clk);
        req_space <= sp;
        {req_valid, req_write, req_vector, req_addr, req_wdata, sw_wait} <= {1'h1, wr, vec, a, d, w};
        do @(negedge clk); while (req_ready !== 1'h1 && ++n < 50);
        @(posedge clk) req_valid <= 1'h0;
        lat = 0;
        ack = 1'h0;
        rwl = 1'h0;
        do begin
            @(negedge clk);
            lat++;
            if (!mem_strobe_n || !io_strobe_n) seen = addr_o;
            ack |= !int_ack_out;
            rwl |= !rw_o;
        end while (rsp_valid !== 1'h1 && lat < 60);
    endtask
    task give_verdict;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        foreach (rows[i]) begin
            access(rows[i].sp, rows[i].wr, 1'h0, rows[i].a, rows[i].d, 3'h3);
            check(seen === rows[i].ea, "address");
            check(rwl === rows[i].wr, "direction");
            check(lat == 5, "latency");
            if (!rows[i].wr) check(rsp_rdata === rows[i].d, "read data");
        end
        access(SPACE_PROG, 1'h0, 1'h1, 20'h7ff80, 16'h0, 3'h3);
        check(ack === 1'h1 && seen === 20'h0ff80, "vector");
        slow <= 1'h1;
        access(SPACE_DATA, 1'h0, 1'h0, 20'h00002, 16'h0, 3'h2);
        check(lat == 8 && rsp_rdata === 16'hc3a5, "stall");
        access(SPACE_DATA, 1'h0, 1'h0, 20'h00002, 16'h0, 3'h1);
        check(lat == 3, "ready ignored below two waits");
        slow <= 1'h0;
        @(posedge clk) {keeper_wr, keeper_wdata} <= 2'h3;
        @(posedge clk) keeper_wr <= 1'h0;
        @(negedge clk);
        check(bus_keeper_en === 1'h1 && data_keep_oe === 1'h1, "keeper");
        kept = data_keep_o;
        repeat (3) @(negedge clk);
        check(data_keep_o === kept && data_i === kept, "keeper hold");
        access(SPACE_DATA, 1'h1, 1'h0, 20'h00005, 16'h6e6e, 3'h0);
        repeat (2) @(negedge clk);
        check(data_keep_o === 16'h6e6e && data_i === 16'h6e6e, "keeper after write");
        access(SPACE_DATA, 1'h0, 1'h0, 20'h3c002, 16'h0, 3'h3);
        repeat (2) @(negedge clk);
        check(data_keep_o === 16'hc3a5 && rsp_rdata === 16'hc3a5, "keeper after read");
        @(posedge clk) float_n <= 1'h0;
        repeat (4) @(negedge clk);
        check({addr_oe, data_oe, int_ack_oe, ctrl_oe} === 4'h0, "float");
        @(posedge clk) {float_n, hold_req_n} <= 2'h2;
        for (int k = 0; k < 8 && hold_ack !== 1'h1; k++) @(negedge clk);
        check(hold_ack === 1'h1 && {addr_oe, data_oe, req_ready} === 3'h0, "hold");
        @(posedge clk) {hold_req_n, rst} <= 2'h3;
        repeat (2) @(negedge clk);
        check(bus_keeper_en === 1'h0 && data_oe === 1'h0, "reset");
        @(posedge clk) rst <= 1'h0;
        access(SPACE_DATA, 1'h0, 1'h0, 20'h3c002, 16'h0, 3'h3);
        check(lat == 5 && rsp_rdata === 16'hc3a5 && seen === 20'h0c002, "after reset");
        give_verdict;
    end
endmodule
